//--- hdl/pso_pkg.sv
/*
  Shared constants and types for the strobed output status block:
  register offsets, status and port C bit positions, modes and carriers.
  Assumes byte-wide registers on a plain strobe port, 8-bit address.
*/
package pso_pkg;

  localparam int unsigned NUM_UNITS = 4;
  localparam int unsigned NUM_PEND  = 2 * NUM_UNITS;

  // Status word offsets of the four interface units
  localparam logic [7:0] OFS_STATUS_UNIT_A = 8'h02;
  localparam logic [7:0] OFS_STATUS_UNIT_B = 8'h06;
  localparam logic [7:0] OFS_STATUS_UNIT_C = 8'h0a;
  localparam logic [7:0] OFS_STATUS_UNIT_D = 8'h0e;
  // Register place inside a unit's four-byte window
  localparam logic [1:0] SUB_PORT_A = 2'h0;
  localparam logic [1:0] SUB_PORT_B = 2'h1;
  localparam logic [1:0] SUB_STATUS = 2'h2;
  localparam logic [1:0] SUB_CONFIG = 2'h3;
  localparam logic [7:0] UNIT_AREA_END = 8'h10;
  // Global interrupt registers
  localparam logic [7:0] OFS_IRQ_CTRL_2  = 8'h10;
  localparam logic [7:0] OFS_GLOBAL_IRQ  = 8'h11;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h12;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h13;

  // Status word and port C bit positions
  localparam int unsigned ST_A_FULL_N   = 7;
  localparam int unsigned ST_A_ALLOW    = 6;
  localparam int unsigned ST_A_IN_FULL  = 5;
  localparam int unsigned ST_A_ALLOW_IN = 4;
  localparam int unsigned ST_A_REQ      = 3;
  localparam int unsigned ST_B_ALLOW    = 2;
  localparam int unsigned ST_B_FULL_N   = 1;
  localparam int unsigned ST_B_REQ      = 0;
  localparam int unsigned PC_A_ACK      = 6;
  localparam int unsigned PC_A_STB      = 4;
  localparam int unsigned PC_B_ACK      = 2;

  // Handshake slots of the status word, per mode
  localparam logic [7:0] HS_A_STROBED = 8'hc8;
  localparam logic [7:0] HS_A_BIDIR   = 8'hf8;
  localparam logic [7:0] HS_B_STROBED = 8'h07;
  // Port C lines driven as handshake outputs, per mode
  localparam logic [7:0] PCO_A_STROBED = 8'h88;
  localparam logic [7:0] PCO_A_BIDIR   = 8'ha8;
  localparam logic [7:0] PCO_B_STROBED = 8'h03;

  // Configuration write fields
  localparam int unsigned CFG_MODE_SET  = 7;
  localparam int unsigned CFG_A_MODE_HI = 6;
  localparam int unsigned CFG_A_MODE_LO = 5;
  localparam int unsigned CFG_A_IN      = 4;
  localparam int unsigned CFG_PC_HI_IN  = 3;
  localparam int unsigned CFG_B_MODE    = 2;
  localparam int unsigned CFG_B_IN      = 1;
  localparam int unsigned CFG_PC_LO_IN  = 0;
  localparam int unsigned BSR_SEL_LSB   = 1;
  localparam int unsigned BSR_VAL       = 0;
  localparam logic [2:0]  BSR_LINE_A_ALLOW    = 3'h6;
  localparam logic [2:0]  BSR_LINE_A_ALLOW_IN = 3'h4;
  localparam logic [2:0]  BSR_LINE_B_ALLOW    = 3'h2;

  typedef enum logic [2:0] {
    AM_BASIC   = 3'b001,
    AM_STROBED = 3'b010,
    AM_BIDIR   = 3'b100
  } pso_amode_e;

  typedef struct packed {
    pso_amode_e a_mode;
    logic       b_strobed;
    logic       a_in;
    logic       b_in;
    logic       pc_hi_in;
    logic       pc_lo_in;
    logic [7:0] a_out;
    logic [7:0] b_out;
    logic [7:0] a_inbuf;
    logic [7:0] pc_latch;
    logic       a_full_n;
    logic       b_full_n;
    logic       a_in_full;
    logic       a_allow;
    logic       a_allow_in;
    logic       b_allow;
    logic       a_req;
    logic       b_req;
    logic       a_ack_n_prev;
    logic       a_stb_n_prev;
    logic       b_ack_n_prev;
  } pso_unit_s;

  typedef struct packed {
    logic [7:0] pa;
    logic [7:0] pb;
    logic [7:0] pc;
  } pso_pins_in_s;

  typedef struct packed {
    logic [7:0] pa;
    logic       pa_oe;
    logic [7:0] pb;
    logic       pb_oe;
    logic [7:0] pc;
    logic [7:0] pc_oe;
  } pso_pins_out_s;

endpackage

//--- hdl/pso_irq.sv
/*
  Sticky interrupt status with mask and one level output.
  Assumes pending levels from the core; write-one-to-clear on status.
*/
`timescale 1ns/1ps
`default_nettype none
module pso_irq (
  input  wire logic                        clk_sys,    // System clock
  input  wire logic                        rst_n,      // Sync reset, low
  input  wire logic [pso_pkg::NUM_PEND-1:0] pend,      // Pending levels
  input  wire logic                        wr_status,  // Clear strobe
  input  wire logic                        wr_mask,    // Mask write strobe
  input  wire logic [7:0]                  wdata,      // Write data
  output var  logic [pso_pkg::NUM_PEND-1:0] status,    // Sticky status
  output var  logic [pso_pkg::NUM_PEND-1:0] mask,      // Mask register
  output var  logic                        irq         // Level interrupt
);
  import pso_pkg::*;

  typedef struct packed {
    logic [NUM_PEND-1:0] prev;
    logic [NUM_PEND-1:0] status;
    logic [NUM_PEND-1:0] mask;
    logic                irq;
  } pso_irq_s;

  pso_irq_s s_q, s_d;

  // Rising pending sets; set beats a same-cycle clear
  always_comb begin
    s_d = s_q;
    s_d.prev = pend;
    if (wr_status) begin
      s_d.status = s_q.status & ~wdata[NUM_PEND-1:0];
    end
    s_d.status = s_d.status | (pend & ~s_q.prev);
    if (wr_mask) begin
      s_d.mask = wdata[NUM_PEND-1:0];
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // State register, cleared by reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign mask   = s_q.mask;
  assign irq    = s_q.irq;
endmodule
`default_nettype wire

//--- hdl/pso_rdata.sv
/*
  Read data register: holds the answer only in the cycle after a read.
  Assumes the read value is settled in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module pso_rdata (
  input  wire logic       clk_sys,  // System clock
  input  wire logic       rst_n,    // Sync reset, low
  input  wire logic       rd,       // Read strobe
  input  wire logic [7:0] value,    // Selected register value
  output var  logic [7:0] rdata     // Registered read data
);
  // Zero outside the answer cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? value : '0;
    end
  end
endmodule
`default_nettype wire

//--- hdl/pso_top.sv
/*
  Four parallel interface units with strobed output and bidirectional
  port A, handshake status words, interrupt gating and register port.
  Assumes pins synchronous to clk_sys and a master that never waits.
*/
// Notes on behaviour
// - Status word per unit at 02/06/0A/0E
// - Bit 7 low after port A write
// - Bits 5-4 general purpose in strobed
// - Port A request only while allowed
// - Pending needs global and control enable
// - Bit 2 allow, set by line 2
// - Bit 0 port B ready request
// - Acknowledge levels never in status word
// - Bidirectional port A, no reconfiguration
// - Bidirectional transfers paced by handshake
// - Port B basic or strobed meanwhile
// - Lines 2-0 free when B basic
// - Port C read shows handshake state
`timescale 1ns/1ps
`default_nettype none
module pso_top (
  input  wire logic                           clk_sys,  // System clock
  input  wire logic                           rst_n,    // Sync reset, low
  input  wire logic [7:0]                     addr,     // Register address
  input  wire logic [7:0]                     wdata,    // Write data
  input  wire logic                           wr,       // Write strobe
  input  wire logic                           rd,       // Read strobe
  output var  logic [7:0]                     rdata,    // Read data
  output var  logic                           irq,      // Interrupt level
  input  wire pso_pkg::pso_pins_in_s  [pso_pkg::NUM_UNITS-1:0] pins_in,  // Pin levels
  output var  pso_pkg::pso_pins_out_s [pso_pkg::NUM_UNITS-1:0] pins_out  // Pin drives
);
  import pso_pkg::*;

  localparam logic [7:0] OFS_STATUS [NUM_UNITS] = '{
    OFS_STATUS_UNIT_A, OFS_STATUS_UNIT_B, OFS_STATUS_UNIT_C, OFS_STATUS_UNIT_D};

  typedef struct packed {
    pso_unit_s     [NUM_UNITS-1:0] unit;
    pso_pins_out_s [NUM_UNITS-1:0] pins;
    logic          [7:0]           icr2;
    logic                          gie;
  } pso_state_s;

  pso_state_s s_q, s_d;

  logic [7:0]          rd_value;
  logic [NUM_PEND-1:0] pend;
  logic [NUM_PEND-1:0] irq_status;
  logic [NUM_PEND-1:0] irq_mask;

  // Unit hit: address inside unit window u at given place
  function automatic logic unit_hit(input logic [7:0] a, input int u, input logic [1:0] sub);
    logic [7:0] base;
    base = OFS_STATUS[u] - {6'h00, SUB_STATUS};
    return (a < UNIT_AREA_END) && (a == (base | {6'h00, sub}));
  endfunction

  // Handshake slots in the status word for the current modes
  function automatic logic [7:0] hs_slots(input pso_unit_s x);
    logic [7:0] m;
    m = '0;
    unique case (x.a_mode)
      AM_BASIC:   m = '0;
      AM_STROBED: m = HS_A_STROBED;
      AM_BIDIR:   m = HS_A_BIDIR;
    endcase
    if (x.b_strobed) begin
      m = m | HS_B_STROBED;
    end
    return m;
  endfunction

  // Handshake lines driven on port C for the current modes
  function automatic logic [7:0] pc_drv(input pso_unit_s x);
    logic [7:0] m;
    m = '0;
    unique case (x.a_mode)
      AM_BASIC:   m = '0;
      AM_STROBED: m = PCO_A_STROBED;
      AM_BIDIR:   m = PCO_A_BIDIR;
    endcase
    if (x.b_strobed) begin
      m = m | PCO_B_STROBED;
    end
    return m;
  endfunction

  // Flag vector in status bit order, requests gated by allows
  function automatic logic [7:0] hs_flags(input pso_unit_s x);
    logic [7:0] f;
    f = '0;
    f[ST_A_FULL_N]   = x.a_full_n;
    f[ST_A_ALLOW]    = x.a_allow;
    f[ST_A_IN_FULL]  = x.a_in_full;
    f[ST_A_ALLOW_IN] = x.a_allow_in;
    f[ST_A_REQ]      = x.a_req;
    f[ST_B_ALLOW]    = x.b_allow;
    f[ST_B_FULL_N]   = x.b_full_n;
    f[ST_B_REQ]      = x.b_req;
    return f;
  endfunction

  // General purpose view: pin level on input halves, latch on outputs
  function automatic logic [7:0] gp_view(input pso_unit_s x, input logic [7:0] pc);
    logic [7:0] g;
    g[7:4] = x.pc_hi_in ? pc[7:4] : x.pc_latch[7:4];
    g[3:0] = x.pc_lo_in ? pc[3:0] : x.pc_latch[3:0];
    return g;
  endfunction

  // Next state of the units, pins and global registers
  always_comb begin
    logic [7:0] hs;
    logic [7:0] drv;
    logic [7:0] gp_oe;
    logic       a_hs;
    logic       a_ack_n;
    logic       a_stb_n;
    logic       b_ack_n;
    pso_unit_s  x;
    hs       = '0;
    drv      = '0;
    gp_oe    = '0;
    a_hs     = 1'b0;
    a_ack_n  = 1'b1;
    a_stb_n  = 1'b1;
    b_ack_n  = 1'b1;
    x        = '0;
    s_d      = s_q;
    rd_value = '0;

    // Global interrupt control registers
    if (wr && addr == OFS_IRQ_CTRL_2) begin
      s_d.icr2 = wdata;
    end
    if (wr && addr == OFS_GLOBAL_IRQ) begin
      s_d.gie = wdata[0];
    end
    if (addr == OFS_IRQ_CTRL_2) begin
      rd_value = s_q.icr2;
    end else if (addr == OFS_GLOBAL_IRQ) begin
      rd_value = {7'h00, s_q.gie};
    end else if (addr == OFS_IRQ_STATUS) begin
      rd_value = irq_status;
    end else if (addr == OFS_IRQ_MASK) begin
      rd_value = irq_mask;
    end

    for (int u = 0; u < NUM_UNITS; u++) begin
      x       = s_q.unit[u];
      a_hs    = (x.a_mode != AM_BASIC);
      a_ack_n = pins_in[u].pc[PC_A_ACK];
      a_stb_n = pins_in[u].pc[PC_A_STB];
      b_ack_n = pins_in[u].pc[PC_B_ACK];

      // Register reads and their side effects
      if (unit_hit(addr, u, SUB_PORT_A)) begin
        if (x.a_mode == AM_BIDIR) begin
          rd_value = x.a_inbuf;
        end else begin
          rd_value = (x.a_mode == AM_BASIC && x.a_in) ? pins_in[u].pa : x.a_out;
        end
        if (rd && x.a_mode == AM_BIDIR) begin
          x.a_in_full = 1'b0;
          x.a_req     = 1'b0;
        end
      end
      if (unit_hit(addr, u, SUB_PORT_B)) begin
        rd_value = (x.b_in && !x.b_strobed) ? pins_in[u].pb : x.b_out;
      end
      // status word read
      // Flags fill handshake slots, never the acknowledge levels
      if (unit_hit(addr, u, SUB_STATUS)) begin
        rd_value = (gp_view(x, pins_in[u].pc) & ~hs_slots(x)) | (hs_flags(x) & hs_slots(x));
      end

      if (wr) begin
        if (unit_hit(addr, u, SUB_PORT_A)) begin
          x.a_out = wdata;
          if (a_hs) begin
            x.a_full_n = 1'b0;
            x.a_req    = 1'b0;
          end
        end
        if (unit_hit(addr, u, SUB_PORT_B)) begin
          x.b_out = wdata;
          if (x.b_strobed) begin
            x.b_full_n = 1'b0;
            x.b_req    = 1'b0;
          end
        end
        if (unit_hit(addr, u, SUB_STATUS)) begin
          x.pc_latch = wdata;
        end
        if (unit_hit(addr, u, SUB_CONFIG)) begin
          if (wdata[CFG_MODE_SET]) begin
            if (wdata[CFG_A_MODE_HI]) begin
              x.a_mode = AM_BIDIR;
            end else if (wdata[CFG_A_MODE_LO]) begin
              x.a_mode = AM_STROBED;
            end else begin
              x.a_mode = AM_BASIC;
            end
            x.b_strobed  = wdata[CFG_B_MODE];
            x.a_in       = wdata[CFG_A_IN];
            x.b_in       = wdata[CFG_B_IN];
            x.pc_hi_in   = wdata[CFG_PC_HI_IN];
            x.pc_lo_in   = wdata[CFG_PC_LO_IN];
            x.a_out      = '0;
            x.b_out      = '0;
            x.pc_latch   = '0;
            x.a_full_n   = 1'b1;
            x.b_full_n   = 1'b1;
            x.a_in_full  = 1'b0;
            x.a_allow    = 1'b0;
            x.a_allow_in = 1'b0;
            x.b_allow    = 1'b0;
            x.a_req      = 1'b0;
            x.b_req      = 1'b0;
          end else begin
            if (a_hs && wdata[BSR_SEL_LSB+:3] == BSR_LINE_A_ALLOW) begin
              x.a_allow = wdata[BSR_VAL];
            end else if (x.a_mode == AM_BIDIR &&
                         wdata[BSR_SEL_LSB+:3] == BSR_LINE_A_ALLOW_IN) begin
              x.a_allow_in = wdata[BSR_VAL];
            end else if (x.b_strobed && wdata[BSR_SEL_LSB+:3] == BSR_LINE_B_ALLOW) begin
              x.b_allow = wdata[BSR_VAL];
            end else begin
              x.pc_latch[wdata[BSR_SEL_LSB+:3]] = wdata[BSR_VAL];
            end
          end
        end
      end

      // peripheral handshake, sets win over clears
      if (a_hs && !a_ack_n) begin
        x.a_full_n = 1'b1;
      end
      if (a_hs && a_ack_n && !x.a_ack_n_prev && x.a_allow) begin
        x.a_req = 1'b1;
      end
      if (x.a_mode == AM_BIDIR && !a_stb_n) begin
        x.a_inbuf   = pins_in[u].pa;
        x.a_in_full = 1'b1;
      end
      if (x.a_mode == AM_BIDIR && a_stb_n && !x.a_stb_n_prev && x.a_allow_in) begin
        x.a_req = 1'b1;
      end
      if (x.b_strobed && !b_ack_n) begin
        x.b_full_n = 1'b1;
      end
      if (x.b_strobed && b_ack_n && !x.b_ack_n_prev && x.b_allow) begin
        x.b_req = 1'b1;
      end
      x.a_ack_n_prev = a_ack_n;
      x.a_stb_n_prev = a_stb_n;
      x.b_ack_n_prev = b_ack_n;

      x.a_req = x.a_req & (x.a_allow | (x.a_mode == AM_BIDIR && x.a_allow_in));
      x.b_req = x.b_req & x.b_allow;
      s_d.unit[u] = x;

      // port A drive: bidirectional only while acknowledged
      s_d.pins[u].pa = x.a_out;
      unique case (x.a_mode)
        AM_BASIC:   s_d.pins[u].pa_oe = ~x.a_in;
        AM_STROBED: s_d.pins[u].pa_oe = 1'b1;
        AM_BIDIR:   s_d.pins[u].pa_oe = ~a_ack_n;
      endcase
      s_d.pins[u].pb    = x.b_out;
      s_d.pins[u].pb_oe = x.b_strobed | ~x.b_in;

      // free lines follow their half direction
      hs    = hs_flags(x);
      drv   = pc_drv(x);
      gp_oe = {{4{~x.pc_hi_in}}, {4{~x.pc_lo_in}}} & ~hs_slots(x);
      s_d.pins[u].pc    = (x.pc_latch & ~drv) | (hs & drv);
      s_d.pins[u].pc_oe = gp_oe | drv;
    end
  end

  // pending needs global and control enable
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      pend[2*u]   = s_q.unit[u].a_req & s_q.gie & s_q.icr2[2*u];
      pend[2*u+1] = s_q.unit[u].b_req & s_q.gie & s_q.icr2[2*u+1];
    end
  end

  // State register; units come up basic with all pins as inputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_q <= '0;
      for (int u = 0; u < NUM_UNITS; u++) begin
        s_q.unit[u].a_mode       <= AM_BASIC;
        s_q.unit[u].a_in         <= 1'b1;
        s_q.unit[u].b_in         <= 1'b1;
        s_q.unit[u].pc_hi_in     <= 1'b1;
        s_q.unit[u].pc_lo_in     <= 1'b1;
        s_q.unit[u].a_full_n     <= 1'b1;
        s_q.unit[u].b_full_n     <= 1'b1;
        s_q.unit[u].a_ack_n_prev <= 1'b1;
        s_q.unit[u].a_stb_n_prev <= 1'b1;
        s_q.unit[u].b_ack_n_prev <= 1'b1;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_out = s_q.pins;

  // Interrupt status, mask and level output
  pso_irq u_irq (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .pend      (pend),
    .wr_status (wr && addr == OFS_IRQ_STATUS),
    .wr_mask   (wr && addr == OFS_IRQ_MASK),
    .wdata     (wdata),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  // Read data, one cycle after the strobe
  pso_rdata u_rdata (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .rd      (rd),
    .value   (rd_value),
    .rdata   (rdata)
  );
endmodule
`default_nettype wire

//--- bench/pso_top_props.sv
/*
  Port checker for pso_top: bus answers, unit A flags and pins, irq.
  Assumes unit A is the one driven in strobed and bidirectional modes.
*/
`timescale 1ns/1ps
`default_nettype none
module pso_top_props (
  input wire logic       clk_sys,  // Clock
  input wire logic       rst_n,    // Reset, low
  input wire logic [7:0] addr,     // Address
  input wire logic [7:0] wdata,    // Write data
  input wire logic       wr,       // Write strobe
  input wire logic       rd,       // Read strobe
  input wire logic [7:0] rdata,    // Read data
  input wire logic       irq,      // Interrupt
  input wire pso_pkg::pso_pins_in_s  [pso_pkg::NUM_UNITS-1:0] pins_in,  // Pin levels
  input wire pso_pkg::pso_pins_out_s [pso_pkg::NUM_UNITS-1:0] pins_out  // Pin drives
);
  import pso_pkg::*;
  logic [1:0] amode_q;
  logic       bstr_q;
  logic       glob_q;
  logic [7:0] ctrl2_q;

  // Mirror of unit A modes and irq enables
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      amode_q <= 2'h0;
      bstr_q  <= 1'b0;
      glob_q  <= 1'b0;
      ctrl2_q <= 8'h00;
    end else if (wr) begin
      if (addr == 8'h03 && wdata[7]) begin
        amode_q <= wdata[6] ? 2'h2 : {1'b0, wdata[5]};
        bstr_q  <= wdata[2];
      end
      if (addr == OFS_IRQ_CTRL_2) ctrl2_q <= wdata;
      if (addr == OFS_GLOBAL_IRQ) glob_q <= wdata[0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_rd_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_rd_unmapped;
    rd && addr >= 8'h14 |-> ##1 rdata == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  property p_a_full;
    (wr && addr == 8'h00 && amode_q == 2'h1 && pins_in[0].pc[PC_A_ACK]) ##2
      pins_out[0].pc_oe[7] |-> !pins_out[0].pc[7];
  endproperty
  a_a_full: assert property (p_a_full) else $error("port A full flag");
  property p_b_full;
    (wr && addr == 8'h01 && bstr_q && pins_in[0].pc[PC_B_ACK]) ##2
      pins_out[0].pc_oe[1] |-> !pins_out[0].pc[1];
  endproperty
  a_b_full: assert property (p_b_full) else $error("port B full flag");
  property p_a_gate;
    (rd && addr == 8'h02 && amode_q == 2'h1) ##1 rdata[3] |-> rdata[6];
  endproperty
  a_a_gate: assert property (p_a_gate) else $error("A request not allowed");
  property p_b_gate;
    (rd && addr == 8'h02 && bstr_q) ##1 rdata[0] |-> rdata[2];
  endproperty
  a_b_gate: assert property (p_b_gate) else $error("B request not allowed");
  property p_irq_src;
    $rose(irq) && !$past(wr && addr == OFS_IRQ_MASK) |-> $past(glob_q && ctrl2_q != 8'h00);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without enables");
  property p_bidir_oe;
    amode_q == 2'h2 && $past(amode_q) == 2'h2 |->
      pins_out[0].pa_oe == !$past(pins_in[0].pc[PC_A_ACK]);
  endproperty
  a_bidir_oe: assert property (p_bidir_oe) else $error("bidir drive");
  property p_bidir_inf;
    (amode_q == 2'h2 && !wr && !pins_in[0].pc[PC_A_STB]) |-> ##2 pins_out[0].pc[5];
  endproperty
  a_bidir_inf: assert property (p_bidir_inf) else $error("input full pin");
  property p_cfg_oe;
    wr && addr == 8'h03 && wdata == 8'hc0 |->
      ##2 pins_out[0].pc_oe == 8'haf && pins_out[0].pb_oe;
  endproperty
  a_cfg_oe: assert property (p_cfg_oe) else $error("bidir pin enables");

  c_irq: cover property ($rose(irq));
  c_strobe: cover property (amode_q == 2'h2 && !pins_in[0].pc[PC_A_STB]);
  c_req: cover property ((rd && addr == 8'h02) ##1 rdata[3]);
endmodule

bind pso_top pso_top_props i_pso_top_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .pins_in(pins_in), .pins_out(pins_out)
);
`default_nettype wire

//--- bench/pso_periph_model.sv
/*
  Peripheral at the pins of all units: acks full flags after a delay
  and strobes bytes into unit A. Released port A and B lines toggle every cycle and port C lines
  other than the ack and strobe lines 6, 4 and 2 count up, except port A while a strobed byte is held.
*/
`timescale 1ns/1ps
`default_nettype none
module pso_periph_model (
  input  wire logic       clk_sys,    // Clock
  input  wire logic       rst_n,      // Reset, low
  input  wire logic [7:0] delay,      // Ack delay, at least 1
  input  wire logic       send_req,   // Strobe a byte into unit A
  input  wire logic [7:0] send_data,  // Byte to strobe
  input  wire pso_pkg::pso_pins_out_s [pso_pkg::NUM_UNITS-1:0] pins_out,  // Device drives
  output var  pso_pkg::pso_pins_in_s  [pso_pkg::NUM_UNITS-1:0] pins_in    // Wire levels
);
  import pso_pkg::*;
  logic [NUM_UNITS-1:0][7:0] cnt_a, cnt_b;
  logic [NUM_UNITS-1:0]      ack_a, ack_b, full_a, full_b, prev_a, prev_b;
  logic [1:0]                stb_cnt;
  logic [7:0]                drv_pa, drv_pb, drv_pc;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_a <= '0;
      cnt_b <= '0;
      ack_a <= '1;
      ack_b <= '1;
      prev_a <= '0;
      prev_b <= '0;
      stb_cnt <= 2'h0;
      drv_pa <= 8'h5a;
      drv_pb <= 8'h3c;
      drv_pc <= 8'h00;
    end else begin
      prev_a <= full_a;
      prev_b <= full_b;
      drv_pb <= ~drv_pb;
      drv_pc <= drv_pc + 8'h01;
      for (int u = 0; u < NUM_UNITS; u++) begin
        ack_a[u] <= cnt_a[u] != 8'h01;
        ack_b[u] <= cnt_b[u] != 8'h01;
        if (cnt_a[u] != 8'h00) cnt_a[u] <= cnt_a[u] - 8'h01;
        else if (full_a[u] && !prev_a[u]) cnt_a[u] <= delay;
        if (cnt_b[u] != 8'h00) cnt_b[u] <= cnt_b[u] - 8'h01;
        else if (full_b[u] && !prev_b[u]) cnt_b[u] <= delay;
      end
      // strobe low one cycle, data held after
      if (send_req) begin
        drv_pa <= send_data;
        stb_cnt <= 2'h3;
      end else if (stb_cnt != 2'h0) stb_cnt <= stb_cnt - 2'h1;
      else drv_pa <= ~drv_pa;
    end
  end

  // Wire levels from both parties' enables
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      full_a[u] = pins_out[u].pc_oe[7] && !pins_out[u].pc[7];
      full_b[u] = pins_out[u].pc_oe[1] && !pins_out[u].pc[1];
      pins_in[u].pa = pins_out[u].pa_oe ? pins_out[u].pa : drv_pa;
      pins_in[u].pb = pins_out[u].pb_oe ? pins_out[u].pb : drv_pb;
      pins_in[u].pc = (pins_out[u].pc & pins_out[u].pc_oe) | (drv_pc & ~pins_out[u].pc_oe);
      pins_in[u].pc[6] = ack_a[u];
      pins_in[u].pc[2] = ack_b[u];
      pins_in[u].pc[4] = (u != 0) || (stb_cnt != 2'h3);
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
/*
  Self-checking bench for pso_top with the peripheral model.
  Reads are noted in a queue and checked by a monitor process.
  Assumes read data one cycle after the strobe and no wait states.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("MISMATCH at %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module tb;
  import pso_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, delay = 8'h02;
  logic wr = 1'b0, rd = 1'b0, irq, send_req = 1'b0, rd_d = 1'b0;
  logic [7:0] send_data = 8'h00, exp_r, d0, d1;
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'h08620de7;
  pso_pins_in_s  [NUM_UNITS-1:0] pins_in;
  pso_pins_out_s [NUM_UNITS-1:0] pins_out;
  int miscompares = 0;
  int samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  pso_top i_pso_top (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pins_in(pins_in), .pins_out(pins_out));
  pso_periph_model i_pso_periph_model (.clk_sys(clk_sys), .rst_n(rst_n), .delay(delay),
    .send_req(send_req), .send_data(send_data), .pins_out(pins_out), .pins_in(pins_in));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  // One bus cycle, held until the next edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read answers against the oldest note
  always @(posedge clk_sys) begin
    if (rd_d) begin
      exp_r = exp_q.pop_front();
      `CHK(rdata, exp_r)
    end
    rd_d <= rd;
  end

  // Hang guard
  initial begin
    #20us;
    miscompares++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int u = 0; u < NUM_UNITS; u++) begin
      d0 = rnd();
      wr_reg(8'(4 * u + 3), 8'h80);
      wr_reg(8'(4 * u + 2), d0);
      rd_reg(8'(4 * u + 2), d0);
    end
    rd_reg(8'h20, 8'h00);
    delay <= 8'h14;
    wr_reg(8'h03, 8'ha4);
    wr_reg(8'h03, 8'h0d);
    wr_reg(8'h03, 8'h05);
    wr_reg(8'h03, 8'h0b);
    wr_reg(8'h03, 8'h09);
    rd_reg(8'h02, 8'hf6);
    d0 = rnd();
    d1 = rnd();
    wr_reg(8'h00, d0);
    wr_reg(8'h01, d1);
    rd_reg(8'h02, 8'h74);
    idle(4);
    `CHK(pins_out[0].pa, d0)
    `CHK(pins_out[0].pb, d1)
    idle(40);
    rd_reg(8'h02, 8'hff);
    rd_reg(OFS_IRQ_STATUS, 8'h00);
    wr_reg(8'h03, 8'h0c);
    rd_reg(8'h02, 8'hb7);
    wr_reg(8'h03, 8'h04);
    rd_reg(8'h02, 8'hb2);
    `CHK(irq, 1'b0)
    delay <= 8'h02;
    wr_reg(8'h03, 8'ha4);
    wr_reg(8'h03, 8'h0d);
    wr_reg(OFS_IRQ_CTRL_2, 8'h01);
    wr_reg(OFS_GLOBAL_IRQ, 8'h01);
    wr_reg(OFS_IRQ_MASK, 8'h00);
    wr_reg(8'h00, rnd());
    idle(12);
    rd_reg(OFS_IRQ_STATUS, 8'h01);
    `CHK(irq, 1'b0)
    wr_reg(OFS_IRQ_MASK, 8'h01);
    idle(2);
    `CHK(irq, 1'b1)
    wr_reg(OFS_IRQ_STATUS, 8'h01);
    idle(2);
    `CHK(irq, 1'b0)
    rd_reg(OFS_IRQ_STATUS, 8'h00);
    wr_reg(8'h03, 8'hc0);
    wr_reg(8'h03, 8'h09);
    wr_reg(8'h03, 8'h0d);
    d0 = rnd();
    send_data <= d0;
    send_req <= 1'b1;
    idle(1);
    send_req <= 1'b0;
    idle(6);
    rd_reg(8'h02, 8'hf8);
    rd_reg(8'h00, d0);
    rd_reg(8'h02, 8'hd0);
    wr_reg(8'h03, 8'h03);
    d1 = rnd();
    wr_reg(8'h00, d1);
    wr_reg(8'h01, d1);
    idle(12);
    rd_reg(8'h02, 8'hda);
    `CHK(pins_out[0].pb, d1)
    idle(2);
    final_report();
  end
endmodule
`default_nettype wire
